// File: src/asct_top.sv
`timescale 1ns/1ps
module asct_top
    import asct_pkg::*;
(
    input  wire logic               clk_in,                 // Sampling clock, 25 MHz
    input  wire logic               arst_n_in,              // Async reset, active low
    input  wire logic               align_marker_input_in,  // Alignment pulse pin
    input  wire logic               capture_edge_select_in, // 0 rising, 1 falling
    input  wire logic               dual_port_in,           // Dual-port output mode
    input  wire logic               interleave_in,          // Interleaved cores
    input  wire logic               event_in,               // Marker source bit
    input  wire logic [ASCT_DW-1:0] sample_a_in,            // Core A sample
    input  wire logic [ASCT_DW-1:0] sample_b_in,            // Core B sample
    input  wire logic               out_ready_in,           // Receiver ready
    output logic                    align_chain_out,        // Chained alignment
    output logic                    data_ready_a_out,       // Data ready A
    output logic                    data_ready_b_out,       // Data ready B
    output logic                    event_marker_out,       // Marker bit
    output logic [ASCT_DW-1:0]      high_a_out,             // High port word A
    output logic [ASCT_DW-1:0]      low_a_out,              // Low port word A
    output logic [ASCT_DW-1:0]      high_b_out,             // High port word B
    output logic                    out_valid_out           // Output word valid
);
    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic       rst_s1_q, rst_n;              // Reset release chain
    logic [5:0] pin_s1_q, pin_s2_q;           // Pin synchronisers
    logic       al_neg_q;                     // Falling-edge capture

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Falling-edge sampling path for the alignment pin
    always_ff @(negedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            al_neg_q <= 1'b0;
        end else begin
            al_neg_q <= align_marker_input_in;
        end
    end

    logic [5:0] pin_raw;                      // Raw pin bundle
    assign pin_raw = {dual_port_in, interleave_in, al_neg_q, align_marker_input_in,
                      capture_edge_select_in, event_in};

    // Two stages before the control logic reads a mode, marker or alignment pin
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    logic align_s, capture_edge_select_s, evt_s, dual_s, ilv_s; // Synchronised levels
    assign dual_s  = pin_s2_q[5];
    assign ilv_s   = pin_s2_q[4];
    assign capture_edge_select_s  = pin_s2_q[1];
    assign evt_s   = pin_s2_q[0];
    assign align_s = capture_edge_select_s ? pin_s2_q[3] : pin_s2_q[2];

    // ------------------------------------------------------------
    // Alignment detect, chain and ready restart
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ASCT_RUN, ASCT_HOLD, ASCT_WAIT} asct_state_type;
    asct_state_type st_q, st_d;               // Ready state
    logic [4:0] cnt_q, cnt_d;                 // Restart counter
    logic       al_prev_q, al_prev_d;         // Previous alignment
    logic       chain_q, chain_d;             // Chained output
    logic       ph_q, ph_d;                   // Dual-port half rate phase
    logic       rdy_a_q, rdy_a_d;             // Ready A
    logic       rdy_b_q, rdy_b_d;             // Ready B
    logic       al_rise;                      // Alignment start
    logic [4:0] rdr;                          // Restart delay for mode

    always_comb begin
        al_rise   = align_s && !al_prev_q;
        rdr       = dual_s ? 5'(ASCT_RDR_DUAL) : 5'(ASCT_RDR_SINGLE);
        al_prev_d = align_s;
        chain_d   = align_s;
        st_d      = st_q;
        cnt_d     = cnt_q;
        ph_d      = ph_q;
        rdy_a_d   = rdy_a_q;
        case (st_q)
            ASCT_RUN: begin
                // Ready toggles at full or half rate
                if (dual_s) begin
                    ph_d = ~ph_q;
                    if (ph_q) begin
                        rdy_a_d = ~rdy_a_q;
                    end
                end else begin
                    rdy_a_d = ~rdy_a_q;
                end
            end
            ASCT_HOLD, ASCT_WAIT: begin
                rdy_a_d = 1'b0;
                ph_d    = 1'b0;
                if (cnt_q == rdr - 5'h1) begin
                    st_d    = ASCT_RUN;
                    rdy_a_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 5'h1;
                    st_d  = ASCT_WAIT;
                end
            end
            default: st_d = ASCT_RUN;
        endcase
        if (al_rise) begin
            st_d    = ASCT_HOLD;
            cnt_d   = 5'h1;
            rdy_a_d = 1'b0;
        end
        // Core B follows A one cycle later when interleaved
        rdy_b_d = ilv_s ? rdy_a_q : rdy_a_d;
    end

    // Register alignment and ready state
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= ASCT_RUN;
            cnt_q     <= 5'h0;
            al_prev_q <= 1'b0;
            chain_q   <= 1'b0;
            ph_q      <= 1'b0;
            rdy_a_q   <= 1'b0;
            rdy_b_q   <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            al_prev_q <= al_prev_d;
            chain_q   <= chain_d;
            ph_q      <= ph_d;
            rdy_a_q   <= rdy_a_d;
            rdy_b_q   <= rdy_b_d;
        end
    end

    // ------------------------------------------------------------
    // Pipeline delay lines, one entry per sampling cycle
    // ------------------------------------------------------------
    asct_pair_type line_q [ASCT_DEPTH];       // Sample history
    asct_pair_type line_d [ASCT_DEPTH];
    logic [ASCT_AW-1:0] wp_q, wp_d;           // Write index

    function automatic logic [ASCT_AW-1:0] tap(input logic [ASCT_AW-1:0] w,
                                               input int unsigned lat);
        // Entry written lat cycles before the output register loads
        tap = w - ASCT_AW'(lat - 1);
    endfunction

    always_comb begin
        line_d           = line_q;
        wp_d             = wp_q + 5'h1;
        line_d[wp_q].a   = '{marker: evt_s, word: sample_a_in};
        line_d[wp_q].b   = '{marker: evt_s, word: sample_b_in};
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ASCT_DEPTH; i++) begin
                line_q[i] <= '0;
            end
            wp_q <= '0;
        end else begin
            line_q <= line_d;
            wp_q   <= wp_d;
        end
    end

    // Latency taps, counted from the sampling edge in whole cycles
    asct_out_type stage;                      // Buffer input
    logic         b_lag;                      // Extra cycle for core B
    always_comb begin
        b_lag        = ilv_s;
        stage.high_a = line_q[tap(wp_q, ASCT_LAT_HIGH)].a.word;
        stage.low_a  = line_q[tap(wp_q, ASCT_LAT_LOW)].a.word;
        stage.high_b = b_lag ? line_q[tap(wp_q, ASCT_LAT_HIGH + 1)].b.word
                             : line_q[tap(wp_q, ASCT_LAT_HIGH)].b.word;
        stage.marker = line_q[tap(wp_q, ASCT_EVENT_MARKER_OUT_A)].a.marker
                     | (ilv_s & line_q[tap(wp_q, ASCT_EVENT_MARKER_OUT_B)].b.marker);
        stage.ready_a = rdy_a_d;
        stage.ready_b = rdy_b_d;
    end

    // ------------------------------------------------------------
    // Output buffer and registered outputs
    // ------------------------------------------------------------
    logic         buf_s_ready, buf_m_valid;  // Buffer handshakes
    asct_out_type buf_data;                  // Buffer output
    logic         take;                      // Output register loads

    asct_buf u_buf (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n),
        .s_valid_in  (1'b1),
        .s_ready_out (buf_s_ready),
        .s_data_in   (stage),
        .m_valid_out (buf_m_valid),
        .m_ready_in  (take),
        .m_data_out  (buf_data)
    );

    asct_out_type out_q, out_d;               // Output register
    logic         vld_q, vld_d;               // Output valid

    always_comb begin
        take  = out_ready_in || !vld_q;
        out_d = out_q;
        vld_d = vld_q;
        if (take) begin
            out_d = buf_data;
            vld_d = buf_m_valid;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
            vld_q <= 1'b0;
        end else begin
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    assign align_chain_out  = chain_q;
    assign data_ready_a_out = rdy_a_q;
    assign data_ready_b_out = rdy_b_q;
    assign event_marker_out = out_q.marker;
    assign high_a_out       = out_q.high_a;
    assign low_a_out        = out_q.low_a;
    assign high_b_out       = out_q.high_b;
    assign out_valid_out    = vld_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Helper counters: cycles since alignment start and since reset, saturating
    logic [4:0] since_q, since_d, fill_q, fill_d;
    always_comb begin
        since_d = al_rise ? 5'h01 : (since_q + {4'h0, since_q != 5'h1f});
        fill_d  = fill_q + {4'h0, fill_q != 5'h1f};
    end
    // Register the helper counters
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            since_q <= 5'h1f;
            fill_q  <= 5'h00;
        end else begin
            since_q <= since_d;
            fill_q  <= fill_d;
        end
    end

    a_chain_delay: assert property (@(posedge clk_in) disable iff (!rst_n)
        align_chain_out == $past(align_s)) else $error("Chained alignment not one cycle");
    a_ready_low: assert property (@(posedge clk_in) disable iff (!rst_n)
        since_q < rdr |-> !data_ready_a_out) else $error("Ready not held low");
    a_ready_restart: assert property (@(posedge clk_in) disable iff (!rst_n)
        since_q == 5'(ASCT_RDR_SINGLE) && !dual_s |-> data_ready_a_out)
        else $error("Ready did not restart at 26");
    a_ready_dual: assert property (@(posedge clk_in) disable iff (!rst_n)
        since_q == 5'(ASCT_RDR_DUAL) && dual_s |-> data_ready_a_out)
        else $error("Ready did not restart at 27");
    a_b_lag: assert property (@(posedge clk_in) disable iff (!rst_n)
        ilv_s && $past(ilv_s) |-> data_ready_b_out == $past(data_ready_a_out))
        else $error("Ready B does not lag A");
    a_edge_sel: assert property (@(posedge clk_in) disable iff (!rst_n)
        align_s == (capture_edge_select_s ? $past(al_neg_q, 2) : $past(align_marker_input_in, 2)))
        else $error("Wrong capture edge");
    a_lat_low: assert property (@(posedge clk_in) disable iff (!rst_n)
        fill_q == 5'h1f |-> stage.low_a == $past(sample_a_in, 19)) else $error("Low port latency");
    a_lat_gap: assert property (@(posedge clk_in) disable iff (!rst_n)
        stage.high_a == $past(stage.low_a, 2)) else $error("High port not two behind low");

    c_align: cover property (@(posedge clk_in) disable iff (!rst_n) al_rise);
    c_restart: cover property (@(posedge clk_in) disable iff (!rst_n)
        st_q == ASCT_WAIT ##1 st_q == ASCT_RUN);
    c_stall: cover property (@(posedge clk_in) disable iff (!rst_n) vld_q && !out_ready_in);
    c_buf_full: cover property (@(posedge clk_in) disable iff (!rst_n) !buf_s_ready);
endmodule // asct_top

// File: src/asct_pkg.sv
package asct_pkg;
    // ------------------------------------------------------------
    // Widths and timing counts
    // ------------------------------------------------------------
    localparam int unsigned ASCT_DW          = 12; // Converted word width
    localparam int unsigned ASCT_SYNC_MIN    = 16; // Least alignment pulse width, cycles
    localparam int unsigned ASCT_SYNCO_DLY   = 1;  // Alignment to chained output, cycles
    localparam int unsigned ASCT_RDR_SINGLE  = 26; // Ready restart, single-port mode
    localparam int unsigned ASCT_RDR_DUAL    = 27; // Ready restart, dual-port mode
    localparam int unsigned ASCT_EVENT_MARKER_OUT_A      = 22; // Marker delay, core A
    localparam int unsigned ASCT_EVENT_MARKER_OUT_B      = 23; // Marker delay, core B
    localparam int unsigned ASCT_LAT_HIGH    = 22; // Word latency, high port
    localparam int unsigned ASCT_LAT_LOW     = 20; // Word latency, low port
    localparam int unsigned ASCT_DEPTH       = 32; // Delay line depth
    localparam int unsigned ASCT_AW          = 5;  // Delay line index width
    localparam int unsigned ASCT_BUF_DEPTH   = 2;  // Output buffer entries

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              marker; // Event marker bit
        logic [ASCT_DW-1:0] word;  // Sample word
    } asct_sample_type;

    typedef struct packed {
        asct_sample_type a;        // Core A sample
        asct_sample_type b;        // Core B sample
    } asct_pair_type;

    typedef struct packed {
        logic               ready_a;  // Data ready A
        logic               ready_b;  // Data ready B
        logic               marker;   // Event marker
        logic [ASCT_DW-1:0] high_a;   // High port word, core A
        logic [ASCT_DW-1:0] low_a;    // Low port word, core A
        logic [ASCT_DW-1:0] high_b;   // High port word, core B
    } asct_out_type;
endpackage

// File: src/asct_buf.sv
`timescale 1ns/1ps
// Two-entry skid buffer, valid/ready on both sides
module asct_buf
    import asct_pkg::*;
(
    input  wire logic          clk_in,     // Sampling clock
    input  wire logic          rst_n_in,   // Synchronised reset
    input  wire logic          s_valid_in, // Upstream valid
    output logic               s_ready_out,// Upstream ready
    input  wire asct_out_type  s_data_in,  // Upstream data
    output logic               m_valid_out,// Downstream valid
    input  wire logic          m_ready_in, // Downstream ready
    output asct_out_type       m_data_out  // Downstream data
);
    asct_out_type mem_q [ASCT_BUF_DEPTH]; // Storage
    asct_out_type mem_d [ASCT_BUF_DEPTH];
    logic         wp_q, wp_d, rp_q, rp_d;  // Pointers
    logic [1:0]   cnt_q, cnt_d;            // Fill level
    logic         push, pop;               // Handshakes

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        push  = s_valid_in && (cnt_q != 2'h2);
        pop   = (cnt_q != 2'h0) && m_ready_in;
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = s_data_in;
            wp_d        = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    // Register stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    assign s_ready_out = (cnt_q != 2'h2);
    assign m_valid_out = (cnt_q != 2'h0);
    assign m_data_out  = mem_q[rp_q];
endmodule // asct_buf

// File: sim/asct_far_end.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-end model: upstream aligner and capture logic
// ------------------------------------------------------------
module asct_far_end
    import asct_pkg::*;
#(
    parameter int unsigned PULSE_W = ASCT_SYNC_MIN // Alignment pulse width, cycles
)
(
    input  wire logic       clk_in,    // Sampling clock
    input  wire logic       fire_in,   // Request one alignment pulse
    input  wire logic [1:0] mode_in,   // 0 prompt, 1 slow, 2 stalled
    output logic            align_out, // Alignment pulse to the block
    output logic            ready_out  // Receiver ready
);
    logic        req_q;   // Latched pulse request
    logic        slow_q;  // Alternating ready in slow mode
    int unsigned left;    // Pulse cycles still to drive

    initial begin
        req_q     = 1'b0;
        slow_q    = 1'b0;
        left      = 0;
        align_out = 1'b0;
        ready_out = 1'b1;
    end

    // Request is taken on the rising edge, acted on at the falling edge
    always @(posedge clk_in) begin
        req_q <= fire_in;
    end

    // Pins change only on the falling edge, away from rising-edge capture
    always @(negedge clk_in) begin
        if (req_q && left == 0) begin
            left = PULSE_W;
        end
        align_out <= (left != 0);
        if (left != 0) begin
            left = left - 1;
        end
        slow_q    <= !slow_q;
        ready_out <= (mode_in == 2'd0) || (mode_in == 2'd1 && slow_q);
    end
endmodule // asct_far_end

// File: sim/test_asct_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Testbench for the alignment and timing block
// ------------------------------------------------------------
module test_asct_top
    import asct_pkg::*;
;
    typedef struct {
        logic dual;    // Dual-port mode
        logic cap;     // Falling-edge capture
        logic ilv;     // Interleaved cores
        int   restart; // Cycles from chained rise to ready restart
        int   per;     // Ready high run length
        int   mk;      // Marker width for a one-cycle event
    } asct_row_type;

    logic               clk_in, arst_n_in, cap_edge, dual, ilv, event_in, fire;
    logic               mon_en, prev_v, align_pin, rdy, chain, rdy_a, rdy_b;
    logic               marker, valid;
    logic [1:0]         mode;            // Far-end ready behaviour
    logic [ASCT_DW-1:0] ctr, sample_a, sample_b, prev_w, high_a, low_a, high_b;
    int                 fails, samples_checked, d0;
    asct_row_type       rows [4];        // Ordinary cases

    // Clock at 25 MHz
    initial clk_in = 1'b0;
    always #20 clk_in = ~clk_in;

    asct_top dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .align_marker_input_in(align_pin),
        .capture_edge_select_in(cap_edge), .dual_port_in(dual), .interleave_in(ilv),
        .event_in(event_in), .sample_a_in(sample_a), .sample_b_in(sample_b),
        .out_ready_in(rdy), .align_chain_out(chain), .data_ready_a_out(rdy_a),
        .data_ready_b_out(rdy_b), .event_marker_out(marker), .high_a_out(high_a),
        .low_a_out(low_a), .high_b_out(high_b), .out_valid_out(valid)
    );

    asct_far_end far (
        .clk_in(clk_in), .fire_in(fire), .mode_in(mode),
        .align_out(align_pin), .ready_out(rdy)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %0h, want %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Ramp stimulus; core B carries a fixed offset to tell the ports apart
    always @(negedge clk_in) begin
        ctr      <= ctr + 12'h001;
        sample_a <= ctr;
        sample_b <= ctr + 12'h100;
    end

    // Word monitor: port spacing, core lag and hold while stalled
    always @(negedge clk_in) begin
        if (mon_en && valid === 1'b1) begin
            check(32'(ASCT_DW'(low_a - high_a)), 32'(ASCT_LAT_HIGH - ASCT_LAT_LOW));
            check(32'(ASCT_DW'(high_b - high_a)), 32'(ilv ? 12'h0ff : 12'h100));
        end
        if (mon_en && prev_v && rdy === 1'b0) begin
            check(32'(high_a), 32'(prev_w));
        end
        prev_v <= (valid === 1'b1);
        prev_w <= high_a;
    end

    // ------------------------------------------------------------
    // One alignment and marker pass for one configuration
    // ------------------------------------------------------------
    task automatic run_row(input asct_row_type r);
        int   d, n, cw, hw;
        logic last_a;
        mon_en   <= 1'b0;
        dual     <= r.dual;
        cap_edge <= r.cap;
        ilv      <= r.ilv;
        repeat (40) @(negedge clk_in);
        mon_en <= 1'b1;
        fire   <= 1'b1;
        @(negedge clk_in);
        fire <= 1'b0;
        d = 1;
        while (chain !== 1'b1 && d < 40) begin
            @(negedge clk_in);
            d++;
        end
        // Falling-edge capture costs exactly one cycle more, as the pin changes on the falling edge
        if (!r.cap) begin
            d0 = d;
        end else begin
            check(d, d0 + 1);
        end
        n  = 0;
        cw = 1;
        while (rdy_a !== 1'b1 && n < 60) begin
            @(negedge clk_in);
            n++;
            if (chain === 1'b1) begin
                cw++;
            end
        end
        check(n, r.restart);
        check(cw, ASCT_SYNC_MIN);
        hw = 0;
        while (rdy_a === 1'b1 && hw < 8) begin
            @(negedge clk_in);
            hw++;
        end
        check(hw, r.per);
        last_a = rdy_a;
        repeat (6) begin
            @(negedge clk_in);
            check(rdy_b, r.ilv ? last_a : rdy_a);
            last_a = rdy_a;
        end
        event_in <= 1'b1;
        @(negedge clk_in);
        event_in <= 1'b0;
        hw = 0;
        repeat (60) begin
            @(negedge clk_in);
            if (marker === 1'b1) begin
                hw++;
            end
        end
        check(hw, r.mk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fails = 0; samples_checked = 0; d0 = 0;
        arst_n_in = 1'b0; cap_edge = 1'b0; dual = 1'b0; ilv = 1'b0;
        event_in = 1'b0; fire = 1'b0; mode = 2'd0; mon_en = 1'b0; prev_v = 1'b0;
        ctr = 12'h000; sample_a = 12'h000; sample_b = 12'h000; prev_w = 12'h000;
        rows[0] = '{1'b0, 1'b0, 1'b0, ASCT_RDR_SINGLE - ASCT_SYNCO_DLY, 1, 1};
        rows[1] = '{1'b1, 1'b0, 1'b0, ASCT_RDR_DUAL - ASCT_SYNCO_DLY, 2, 1};
        rows[2] = '{1'b0, 1'b1, 1'b1, ASCT_RDR_SINGLE - ASCT_SYNCO_DLY, 1, 2};
        rows[3] = '{1'b1, 1'b1, 1'b1, ASCT_RDR_DUAL - ASCT_SYNCO_DLY, 2, 2};
        repeat (6) @(negedge clk_in);
        arst_n_in <= 1'b1;
        repeat (4) @(negedge clk_in);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // Receiver stalls, then accepts every other cycle
        mode <= 2'd2;
        repeat (12) @(negedge clk_in);
        check(valid, 1'b1);
        mode <= 2'd1;
        repeat (20) @(negedge clk_in);
        mode <= 2'd0;
        repeat (10) @(negedge clk_in);
        // Reset in mid-run clears chain, both readies, marker, valid and high_a, then alignment works again
        mon_en    <= 1'b0;
        arst_n_in <= 1'b0;
        repeat (3) @(negedge clk_in);
        check(32'({chain, rdy_a, rdy_b, marker, valid, high_a}), 32'h0);
        arst_n_in <= 1'b1;
        repeat (4) @(negedge clk_in);
        run_row(rows[1]);
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk_in);
        fails++;
        results();
    end
endmodule // test_asct_top
